// [rtl/fdvs_defs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  frequency delta / vector surge stage. Included by the design files only.
*/
`ifndef FDVS_DEFS_SVH
`define FDVS_DEFS_SVH

// Byte offsets on the register bus
`define FDVS_ADR_CTRL     8'h00
`define FDVS_ADR_PICKUP   8'h04
`define FDVS_ADR_DFLIM    8'h08
`define FDVS_ADR_DTWIN    8'h0C
`define FDVS_ADR_VSLIM    8'h10
`define FDVS_ADR_STATUS   8'h14
`define FDVS_ADR_IRQ_STAT 8'h18
`define FDVS_ADR_IRQ_CLR  8'h1C
`define FDVS_ADR_IRQ_EN   8'h20

// Control fields
`define FDVS_CTRL_MODE_LSB 0
`define FDVS_CTRL_VSN_LSB  2

// Reset values
`define FDVS_RST_CTRL   32'h0000000C
`define FDVS_RST_PICKUP 20'h0BF68
`define FDVS_RST_DFLIM  20'h003E8
`define FDVS_RST_DTWIN  16'h0064
`define FDVS_RST_VSLIM  20'h02B67

// Interrupt status bits
`define FDVS_IRQ_ALARM  0
`define FDVS_IRQ_TRIP   1
`define FDVS_IRQ_EXPIRE 2
`define FDVS_IRQ_VSURGE 3

// Timing: clock period and one millisecond, in ns
`define FDVS_CLK_NS 50
`define FDVS_MS_NS  1000000

// Release band is one part in this many of the pickup value (0.05 %)
`define FDVS_HYST_DIV 20'h007D0

`endif

// [rtl/fdvs_pkg.sv]
/*
  Types of the frequency delta / vector surge stage.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fdvs_pkg;

  // Operating mode, encoded as held in the control register
  typedef enum logic [1:0] {
    MODE_OFF      = 2'h0,
    MODE_UNDER_DF = 2'h1,
    MODE_OVER_DF  = 2'h2,
    MODE_VSURGE   = 2'h3
  } fdvs_mode_e;

  // Supervision window sequencer
  typedef enum logic [1:0] {
    DF_IDLE,
    DF_WATCH,
    DF_TRIP,
    DF_DISARM
  } fdvs_dfst_e;

  typedef logic [19:0] fdvs_freq_t;

endpackage

// [rtl/fdvs_cycle_meter.sv]
/*
  Cycle duration meter for one line voltage.
  Counts clock cycles between zero crossings, compares each period with the
  period before it and flags a vector surge. Zero-crossing strobes are one
  cycle pulses on the block clock.
*/
`timescale 1ns/100ps
module fdvs_cycle_meter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       zc,
  input  wire logic [19:0] lim,
  output logic            surge
);

  logic [19:0] cnt_ff;
  logic [19:0] ref_ff;
  logic        ref_ok_ff;
  logic        seen_ff;
  logic        surge_ff;

  // Magnitude of the period deviation, early or late crossing alike
  function automatic logic [19:0] fdvs_absdiff(input logic [19:0] a, input logic [19:0] b);
    fdvs_absdiff = (a > b) ? a - b : b - a;
  endfunction

  // Period counter restarts on every crossing and saturates on a lost one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 20'h00000;
    end else if (!enable || zc) begin
      cnt_ff <= 20'h00001;
    end else if (cnt_ff != 20'hFFFFF) begin
      cnt_ff <= cnt_ff + 20'h00001;
    end
  end

  // Last good period is the reference for the next one; the span up to the
  // first crossing after enable is a partial period and never a reference
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_ff    <= 20'h00000;
      ref_ok_ff <= 1'b0;
      seen_ff   <= 1'b0;
    end else if (!enable) begin
      ref_ok_ff <= 1'b0;
      seen_ff   <= 1'b0;
    end else if (zc) begin
      ref_ff    <= cnt_ff;
      ref_ok_ff <= seen_ff && (cnt_ff != 20'hFFFFF);
      seen_ff   <= 1'b1;
    end
  end

  // Surge flag holds for one period; cleared at once when the phase drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      surge_ff <= 1'b0;
    end else if (!enable) begin
      surge_ff <= 1'b0;
    end else if (zc) begin
      surge_ff <= ref_ok_ff && (fdvs_absdiff(cnt_ff, ref_ff) > lim);
    end
  end

  assign surge = surge_ff;

endmodule

// [rtl/fdvs_top.sv]
/*
  Frequency stage with underfrequency or overfrequency plus frequency
  change inside a supervision window, and vector surge supervision.
  Assumes the measurement front end delivers per-phase frequency (mHz),
  zero-crossing strobes and voltage flags on clk; the block command comes
  from a pin and is synchronised here. Registers sit on classic Wishbone.
*/
`timescale 1ns/100ps
`include "fdvs_defs.svh"

// Notes on behaviour
// - All three voltages low blocks frequency evaluation
// - Compare frequency with pickup, change with limit
// - Change counts as fall (under) or rise (over)
// - Crossing without block raises alarm, starts window
// - Trip when change reaches limit inside window
// - Window expiry disarms until frequency crosses anew
// - Cycle duration measured, restarted each zero crossing
// - Deviation from reference period gives surge angle
// - Required surging phases: three, two or one
// - Surge without block: alarm and trip at once
// - Phase loss inhibits vector surge trip
// - Low-voltage lockout acts before surge result
// - Mains failure trip well within 60 ms
// - Over stage releases only 0.05 % below pickup
// - Under stage releases only 0.05 % above pickup
module fdvs_top #(
  parameter int unsigned MS_CYCLES = `FDVS_MS_NS / `FDVS_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [19:0] line_voltage_one_two_freq,
  input  wire logic [19:0] line_voltage_two_three_freq,
  input  wire logic [19:0] line_voltage_three_one_freq,
  input  wire logic        line_voltage_one_two_zc,
  input  wire logic        line_voltage_two_three_zc,
  input  wire logic        line_voltage_three_one_zc,
  input  wire logic [2:0]  low_volt,
  input  wire logic        phase_loss,
  input  wire logic        block_cmd,
  output logic             alarm,
  output logic             trip,
  output logic             irq
);

  logic [31:0]             ctrl_ff;
  fdvs_pkg::fdvs_freq_t    pickup_ff;
  fdvs_pkg::fdvs_freq_t    dflim_ff;
  logic [15:0]             dtwin_ff;
  logic [19:0]             vslim_ff;
  logic [3:0]              irq_stat_ff;
  logic [3:0]              irq_en_ff;
  logic                    irq_ff;
  logic [31:0]             dat_ff;
  logic                    ack_ff;
  logic                    blk_s1_ff;
  logic                    blk_s2_ff;
  logic                    blk_s3_ff;
  logic                    blk_ff;
  logic [14:0]             ms_cnt_ff;
  logic                    ms_tick_ff;
  logic [15:0]             dt_cnt_ff;
  fdvs_pkg::fdvs_freq_t    fstart_ff;
  fdvs_pkg::fdvs_dfst_e    st_ff;
  fdvs_pkg::fdvs_dfst_e    nxt_st;
  logic                    alarm_ff;
  logic                    trip_ff;
  logic                    nxt_alarm;
  logic                    nxt_trip;
  fdvs_pkg::fdvs_mode_e    mode;
  fdvs_pkg::fdvs_freq_t    f_ph [3];
  fdvs_pkg::fdvs_freq_t    f_ev;
  fdvs_pkg::fdvs_freq_t    delta;
  fdvs_pkg::fdvs_freq_t    hyst;
  logic [2:0]              zc;
  logic [2:0]              vs_flag;
  logic [1:0]              vs_cnt;
  logic [1:0]              vs_need;
  logic                    is_df;
  logic                    under;
  logic                    eval_blk;
  logic                    beyond;
  logic                    released;
  logic                    dt_exp;
  logic                    vs_hit;
  logic                    bus_req;
  logic [3:0]              irq_ev;
  logic [31:0]             rd_mux;
  logic [31:0]             lane_mask;

  // Bit mask of the byte lanes enabled for a write
  function automatic logic [31:0] fdvs_lane_mask(input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      fdvs_lane_mask[i*8 +: 8] = sel[i] ? 8'hFF : 8'h00;
    end
  endfunction

  // Frequency beyond the pickup level in the direction of the mode
  function automatic logic fdvs_beyond(input logic und, input logic [19:0] f,
                                       input logic [19:0] thr);
    fdvs_beyond = und ? (f < thr) : (f > thr);
  endfunction

  // Pickup release only outside the hysteresis band
  function automatic logic fdvs_released(input logic und, input logic [19:0] f,
                                         input logic [19:0] thr, input logic [19:0] h);
    fdvs_released = und ? ({1'b0, f} >= {1'b0, thr} + {1'b0, h}) : (f + h <= thr);
  endfunction

  assign f_ph[0] = line_voltage_one_two_freq;
  assign f_ph[1] = line_voltage_two_three_freq;
  assign f_ph[2] = line_voltage_three_one_freq;
  assign zc      = {line_voltage_three_one_zc, line_voltage_two_three_zc,
                    line_voltage_one_two_zc};
  assign mode    = fdvs_pkg::fdvs_mode_e'(ctrl_ff[`FDVS_CTRL_MODE_LSB +: 2]);
  assign under   = (mode == fdvs_pkg::MODE_UNDER_DF);
  assign is_df   = under || (mode == fdvs_pkg::MODE_OVER_DF);
  assign eval_blk = &low_volt;
  assign hyst    = pickup_ff / `FDVS_HYST_DIV;
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign lane_mask = fdvs_lane_mask(wb_sel_i);

  // Block command pin: three stages, accepted once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk_s1_ff <= 1'b0;
      blk_s2_ff <= 1'b0;
      blk_s3_ff <= 1'b0;
      blk_ff    <= 1'b0;
    end else begin
      blk_s1_ff <= block_cmd;
      blk_s2_ff <= blk_s1_ff;
      blk_s3_ff <= blk_s2_ff;
      if (blk_s2_ff == blk_s3_ff) begin
        blk_ff <= blk_s3_ff;
      end
    end
  end

  // Millisecond enable for the supervision window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_ff  <= 15'h0000;
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == 15'(MS_CYCLES - 1)) begin
      ms_cnt_ff  <= 15'h0000;
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff  <= ms_cnt_ff + 15'h0001;
      ms_tick_ff <= 1'b0;
    end
  end

  // Most extreme frequency among phases with voltage: any-phase pickup
  always_comb begin
    f_ev = under ? 20'hFFFFF : 20'h00000;
    for (int i = 0; i < 3; i++) begin
      if (!low_volt[i] && (under ? (f_ph[i] < f_ev) : (f_ph[i] > f_ev))) begin
        f_ev = f_ph[i];
      end
    end
  end

  // Change since the crossing, only in the direction of the mode
  always_comb begin
    if (under) begin
      delta = (fstart_ff > f_ev) ? fstart_ff - f_ev : 20'h00000;
    end else begin
      delta = (f_ev > fstart_ff) ? f_ev - fstart_ff : 20'h00000;
    end
  end

  assign beyond   = fdvs_beyond(under, f_ev, pickup_ff);
  assign released = fdvs_released(under, f_ev, pickup_ff, hyst);
  assign dt_exp   = (dt_cnt_ff >= dtwin_ff);

  // Window sequencer; block or lost voltage drops everything at once
  always_comb begin
    nxt_st = st_ff;
    if (!is_df || blk_ff || eval_blk) begin
      nxt_st = fdvs_pkg::DF_IDLE;
    end else begin
      unique case (st_ff)
        fdvs_pkg::DF_IDLE: begin
          if (beyond) begin
            nxt_st = fdvs_pkg::DF_WATCH;
          end
        end
        fdvs_pkg::DF_WATCH: begin
          if (released) begin
            nxt_st = fdvs_pkg::DF_IDLE;
          end else if (beyond && delta >= dflim_ff) begin
            nxt_st = fdvs_pkg::DF_TRIP;
          end else if (dt_exp) begin
            nxt_st = fdvs_pkg::DF_DISARM;
          end
        end
        fdvs_pkg::DF_TRIP, fdvs_pkg::DF_DISARM: begin
          if (released) begin
            nxt_st = fdvs_pkg::DF_IDLE;
          end
        end
      endcase
    end
  end

  // Sequencer state and the frequency captured at the crossing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff     <= fdvs_pkg::DF_IDLE;
      fstart_ff <= 20'h00000;
    end else begin
      st_ff <= nxt_st;
      if (st_ff == fdvs_pkg::DF_IDLE && nxt_st == fdvs_pkg::DF_WATCH) begin
        fstart_ff <= f_ev;
      end
    end
  end

  // Window timer counts milliseconds only while watching
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dt_cnt_ff <= 16'h0000;
    end else if (st_ff != fdvs_pkg::DF_WATCH) begin
      dt_cnt_ff <= 16'h0000;
    end else if (ms_tick_ff && !dt_exp) begin
      dt_cnt_ff <= dt_cnt_ff + 16'h0001;
    end
  end

  // One meter per line voltage; a phase without voltage is not measured
  for (genvar g = 0; g < 3; g++) begin : g_meter
    fdvs_cycle_meter u_meter (
      .clk    (clk),
      .rst    (rst),
      .enable ((mode == fdvs_pkg::MODE_VSURGE) && !low_volt[g]),
      .zc     (zc[g]),
      .lim    (vslim_ff),
      .surge  (vs_flag[g])
    );
  end

  // Phase vote; lockouts are combinational so they beat the registered surge
  assign vs_cnt  = {1'b0, vs_flag[0]} + {1'b0, vs_flag[1]} + {1'b0, vs_flag[2]};
  assign vs_need = (ctrl_ff[`FDVS_CTRL_VSN_LSB +: 2] == 2'h0) ? 2'h3
                 : ctrl_ff[`FDVS_CTRL_VSN_LSB +: 2];
  assign vs_hit  = (mode == fdvs_pkg::MODE_VSURGE) && (vs_cnt >= vs_need)
                 && !blk_ff && !phase_loss && !eval_blk;

  assign nxt_alarm = is_df ? (nxt_st == fdvs_pkg::DF_WATCH || nxt_st == fdvs_pkg::DF_TRIP)
                   : vs_hit;
  assign nxt_trip  = is_df ? (nxt_st == fdvs_pkg::DF_TRIP) : vs_hit;

  // Outputs are registered so the relay contacts see no glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_ff <= 1'b0;
      trip_ff  <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
      trip_ff  <= nxt_trip;
    end
  end

  always_comb begin
    irq_ev                  = 4'h0;
    irq_ev[`FDVS_IRQ_ALARM]  = nxt_alarm && !alarm_ff;
    irq_ev[`FDVS_IRQ_TRIP]   = nxt_trip && !trip_ff;
    irq_ev[`FDVS_IRQ_EXPIRE] = (st_ff == fdvs_pkg::DF_WATCH) && (nxt_st == fdvs_pkg::DF_DISARM);
    irq_ev[`FDVS_IRQ_VSURGE] = vs_hit && !trip_ff;
  end

  // Sticky status: an event in the clearing cycle survives the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= 4'h0;
      irq_ff      <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_en_ff);
      if (bus_req && wb_we_i && {wb_adr_i[7:2], 2'b00} == `FDVS_ADR_IRQ_CLR) begin
        irq_stat_ff <= (irq_stat_ff & ~(wb_dat_i[3:0] & lane_mask[3:0])) | irq_ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_ev;
      end
    end
  end

  // Register writes; read-only and unmapped offsets ignore the data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff   <= `FDVS_RST_CTRL;
      pickup_ff <= `FDVS_RST_PICKUP;
      dflim_ff  <= `FDVS_RST_DFLIM;
      dtwin_ff  <= `FDVS_RST_DTWIN;
      vslim_ff  <= `FDVS_RST_VSLIM;
      irq_en_ff <= 4'h0;
    end else if (bus_req && wb_we_i) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        `FDVS_ADR_CTRL:   ctrl_ff   <= ((ctrl_ff & ~lane_mask) | (wb_dat_i & lane_mask))
                                       & 32'h0000000F;
        `FDVS_ADR_PICKUP: pickup_ff <= (pickup_ff & ~lane_mask[19:0])
                                       | (wb_dat_i[19:0] & lane_mask[19:0]);
        `FDVS_ADR_DFLIM:  dflim_ff  <= (dflim_ff & ~lane_mask[19:0])
                                       | (wb_dat_i[19:0] & lane_mask[19:0]);
        `FDVS_ADR_DTWIN:  dtwin_ff  <= (dtwin_ff & ~lane_mask[15:0])
                                       | (wb_dat_i[15:0] & lane_mask[15:0]);
        `FDVS_ADR_VSLIM:  vslim_ff  <= (vslim_ff & ~lane_mask[19:0])
                                       | (wb_dat_i[19:0] & lane_mask[19:0]);
        `FDVS_ADR_IRQ_EN: irq_en_ff <= (irq_en_ff & ~lane_mask[3:0])
                                       | (wb_dat_i[3:0] & lane_mask[3:0]);
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    unique case ({wb_adr_i[7:2], 2'b00})
      `FDVS_ADR_CTRL:     rd_mux = ctrl_ff;
      `FDVS_ADR_PICKUP:   rd_mux = {12'h000, pickup_ff};
      `FDVS_ADR_DFLIM:    rd_mux = {12'h000, dflim_ff};
      `FDVS_ADR_DTWIN:    rd_mux = {16'h0000, dtwin_ff};
      `FDVS_ADR_VSLIM:    rd_mux = {12'h000, vslim_ff};
      `FDVS_ADR_STATUS:   rd_mux = {24'h000000, eval_blk, vs_flag,
                                    st_ff == fdvs_pkg::DF_DISARM,
                                    st_ff == fdvs_pkg::DF_WATCH, trip_ff, alarm_ff};
      `FDVS_ADR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_ff};
      `FDVS_ADR_IRQ_EN:   rd_mux = {28'h0000000, irq_en_ff};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Every access is answered one cycle after the request, unmapped ones too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_ff <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign alarm    = alarm_ff;
  assign trip     = trip_ff;
  assign irq      = irq_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_eval_block;
    (is_df && eval_blk) |=> (st_ff == fdvs_pkg::DF_IDLE) && !alarm_ff && !trip_ff;
  endproperty
  a_eval_block: assert property (p_eval_block) else $error("evaluation not blocked");

  property p_alarm_cross;
    (is_df && st_ff == fdvs_pkg::DF_IDLE && beyond && !blk_ff && !eval_blk)
      |=> alarm_ff && (st_ff == fdvs_pkg::DF_WATCH) && (fstart_ff == $past(f_ev));
  endproperty
  a_alarm_cross: assert property (p_alarm_cross) else $error("no alarm on crossing");

  property p_trip_df;
    ($rose(trip_ff) && is_df) |-> $past(beyond && (delta >= dflim_ff));
  endproperty
  a_trip_df: assert property (p_trip_df) else $error("trip without change limit");

  property p_dir;
    (under && f_ev >= fstart_ff) or (!under && f_ev <= fstart_ff) |-> (delta == 20'h00000);
  endproperty
  a_dir: assert property (p_dir) else $error("change counted in wrong direction");

  property p_expire;
    (is_df && st_ff == fdvs_pkg::DF_WATCH && dt_exp && !released && !blk_ff && !eval_blk
     && !(beyond && delta >= dflim_ff))
      |=> (st_ff == fdvs_pkg::DF_DISARM) && !trip_ff ##1 !trip_ff;
  endproperty
  a_expire: assert property (p_expire) else $error("window expiry not disarmed");

  property p_vs;
    vs_hit |=> alarm_ff && trip_ff;
  endproperty
  a_vs: assert property (p_vs) else $error("surge did not trip at once");

  property p_vs_need;
    (mode == fdvs_pkg::MODE_VSURGE && vs_cnt < vs_need) |=> !trip_ff;
  endproperty
  a_vs_need: assert property (p_vs_need) else $error("too few phases tripped");

  property p_ploss;
    (mode == fdvs_pkg::MODE_VSURGE && phase_loss) |=> !trip_ff && !alarm_ff;
  endproperty
  a_ploss: assert property (p_ploss) else $error("trip despite phase loss");

  property p_uvlock;
    (mode == fdvs_pkg::MODE_VSURGE && eval_blk) |=> !trip_ff ##1 (vs_flag == 3'h0);
  endproperty
  a_uvlock: assert property (p_uvlock) else $error("lockout too slow");

  property p_hyst_over;
    (mode == fdvs_pkg::MODE_OVER_DF && st_ff == fdvs_pkg::DF_WATCH && !blk_ff
     && !eval_blk && f_ev + hyst > pickup_ff) |=> (st_ff != fdvs_pkg::DF_IDLE);
  endproperty
  a_hyst_over: assert property (p_hyst_over) else $error("over stage released early");

  property p_hyst_under;
    (under && st_ff == fdvs_pkg::DF_WATCH && !blk_ff && !eval_blk
     && {1'b0, f_ev} < {1'b0, pickup_ff} + {1'b0, hyst}) |=> (st_ff != fdvs_pkg::DF_IDLE);
  endproperty
  a_hyst_under: assert property (p_hyst_under) else $error("under stage released early");

  property p_off;
    (mode == fdvs_pkg::MODE_OFF) |=> !alarm_ff && !trip_ff;
  endproperty
  a_off: assert property (p_off) else $error("output active with mode off");

  c_df_trip: cover property (is_df && st_ff == fdvs_pkg::DF_WATCH ##1
                             st_ff == fdvs_pkg::DF_TRIP);
  c_disarm:  cover property (st_ff == fdvs_pkg::DF_DISARM ##1 st_ff == fdvs_pkg::DF_IDLE);
  c_vs_trip: cover property ($rose(trip_ff) && mode == fdvs_pkg::MODE_VSURGE);

endmodule

// [sim/fdvs_front_end.sv]
/*
  Measurement front-end model: frequency, zero crossings, voltage flags.
  Assumes the bench sets level, cycle length and flags on clk.
*/
`timescale 1ns/100ps
module fdvs_front_end (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [19:0] f_set,
  input  wire logic [15:0] per,
  input  wire logic [2:0]  lv_set,
  input  wire logic        pl_set,
  output logic      [19:0] freq,
  output logic             zc,
  output logic      [2:0]  low_volt,
  output logic             phase_loss
);
  logic [15:0] cnt_ff;
  // All lines refresh on the block clock; strobe is one cycle long
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
      zc     <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff >= per - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
      zc     <= (cnt_ff >= per - 16'h0001);
    end
  end
  // Levels follow the bench one cycle late, like a registered front end
  always_ff @(posedge clk) begin
    freq       <= f_set;
    low_volt   <= lv_set;
    phase_loss <= pl_set;
  end
endmodule

// [sim/tb.sv]
/*
  Self-checking bench of the frequency stage.
  Assumes fdvs_top on classic Wishbone and the front-end model.
*/
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        blk = 1'b0;
  logic        pl = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rd;
  logic [31:0] q;
  logic        ack;
  logic        alarm;
  logic        trip;
  logic        irq;
  logic        zc;
  logic        ploss;
  logic [19:0] fset = 20'h0C350;
  logic [19:0] freq;
  logic [15:0] per = 16'h0190;
  logic [2:0]  lv = 3'h0;
  logic [2:0]  lvo;
  int          n_errors = 0;
  int          check_count = 0;

  always #25 clk = ~clk;

  fdvs_front_end fdvs_front_end_i (.clk(clk), .rst(rst), .f_set(fset), .per(per),
    .lv_set(lv), .pl_set(pl), .freq(freq), .zc(zc), .low_volt(lvo), .phase_loss(ploss));

  // Small ms tick keeps the window short in simulation
  fdvs_top #(.MS_CYCLES(20)) fdvs_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rd), .wb_ack_o(ack), .line_voltage_one_two_freq(freq),
    .line_voltage_two_three_freq(freq), .line_voltage_three_one_freq(freq),
    .line_voltage_one_two_zc(zc), .line_voltage_two_three_zc(zc),
    .line_voltage_three_one_zc(zc), .low_volt(lvo), .phase_loss(ploss),
    .block_cmd(blk), .alarm(alarm), .trip(trip), .irq(irq));

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One classic cycle; request held until ack is seen
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task chkr(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Pins compared as {alarm, trip}
  task chko(input logic [1:0] exp);
    chkr({30'h0, alarm, trip}, {30'h0, exp});
  endtask

  task setf(input logic [19:0] f, input int n);
    @(posedge clk);
    fset <= f;
    tick(n);
  endtask

  task t_regs;
    wb(1'b0, 8'h00, 32'h0);
    chkr(q, 32'h0000000C);
    wb(1'b1, 8'h14, 32'hFF);
    wb(1'b0, 8'h14, 32'h0);
    chkr(q, 32'h0);
    wb(1'b0, 8'h24, 32'h0);
    chkr(q, 32'h0);
    setf(20'h0BB80, 3);
    chko(2'b00);
  endtask

  task t_under;
    setf(20'h0C350, 1);
    wb(1'b1, 8'h0C, 32'h2);
    wb(1'b1, 8'h20, 32'h2);
    wb(1'b1, 8'h00, 32'h0D);
    setf(20'h0BF04, 2);
    chko(2'b10);
    setf(20'h0BB1C, 3);
    chko(2'b11);
    tick(2);
    chkr({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h1C, 32'h2);
    tick(2);
    chkr({31'h0, irq}, 32'h0);
    @(posedge clk);
    blk <= 1'b1;
    tick(6);
    chko(2'b00);
    fset <= 20'h0C350;
    tick(3);
    blk <= 1'b0;
  endtask

  task t_over;
    wb(1'b1, 8'h04, 32'h0C738);
    wb(1'b1, 8'h00, 32'h0E);
    setf(20'h0C79C, 2);
    chko(2'b10);
    setf(20'h0CB84, 3);
    chko(2'b11);
    setf(20'h0C724, 3);
    chko(2'b11);
    setf(20'h0C71A, 3);
    chko(2'b00);
  endtask

  task t_expire;
    wb(1'b1, 8'h04, 32'h0BF68);
    setf(20'h0C350, 1);
    wb(1'b1, 8'h00, 32'h0D);
    setf(20'h0BF04, 2);
    chko(2'b10);
    tick(60);
    chko(2'b00);
    wb(1'b0, 8'h14, 32'h0);
    chkr(q & 32'h8, 32'h8);
    setf(20'h0BF7C, 3);
    setf(20'h0BF04, 3);
    chko(2'b00);
    setf(20'h0BF86, 3);
    setf(20'h0BF04, 3);
    chko(2'b10);
    lv <= 3'h7;
    tick(3);
    chko(2'b00);
    lv <= 3'h0;
    setf(20'h0C350, 3);
  endtask

  // Long cycle on all phases: trip, then with phase loss and with all voltages low none
  task t_surge;
    wb(1'b1, 8'h10, 32'h64);
    wb(1'b1, 8'h00, 32'h07);
    for (int i = 0; i < 3; i++) begin
      tick(1300);
      pl <= (i == 1);
      lv <= (i == 2) ? 3'h7 : 3'h0;
      tick(1300);
      per <= 16'h02BC;
      tick(710);
      chko((i == 0) ? 2'b11 : 2'b00);
      per <= 16'h0190;
    end
    pl <= 1'b0;
    lv <= 3'h0;
    tick(1300);
    chko(2'b00);
  endtask

  task results;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    results;
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_under;
    t_over;
    t_expire;
    t_surge;
    results;
  end
endmodule
